/* File: jcu_checker.sv */
/*
 * port assertions for the character link block.
 * assumes binding into every jcu_top instance, one clock domain.
 */
module jcu_checker #(
    parameter DEPTH = 64,
    parameter CNT_W = 7
) (
    // clock, reset and register port
    input wire sys_clk_i,
    input wire rst_i,
    input wire [31:0] bus_addr_i,
    input wire bus_rd_i,
    input wire bus_wr_i,
    input wire [31:0] bus_wdata_i,
    input wire [31:0] bus_rdata_o,
    input wire bus_ack_o,
    // host link
    input wire link_clk_i,
    input wire link_sel_i,
    input wire link_din_i,
    input wire link_dout_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire rd_data = bus_rd_i && bus_addr_i == 32'hFF201000;
    wire rd_ctrl = bus_rd_i && bus_addr_i == 32'hFF201004;
    // cycles since the select pin was last high, saturating
    reg [3:0] quiet_q;
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            quiet_q <= 4'hF;
        end else begin
            quiet_q <= link_sel_i ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
        end
    end
    a_ack_follows_strobe:
        assert property ((bus_rd_i || bus_wr_i) |=> bus_ack_o) else $error("missing ack");
    a_ack_needs_strobe:
        assert property (!bus_rd_i && !bus_wr_i |=> !bus_ack_o) else $error("stray ack");
    a_unmapped_reads_zero:
        assert property (bus_rd_i && !rd_data && !rd_ctrl |=> bus_rdata_o == 32'h0) else $error("unmapped data");
    a_write_data_zero:
        assert property (bus_wr_i |=> bus_rdata_o == 32'h0) else $error("write returned data");
    a_empty_no_count:
        assert property (rd_data |=> bus_rdata_o[14:8] == 7'h0 && (bus_rdata_o[15] || bus_rdata_o[31:16] == 16'h0))
            else $error("bad empty read");
    a_ctrl_layout:
        assert property (rd_ctrl |=> bus_rdata_o[31:16] <= DEPTH && bus_rdata_o[15:11] == 5'h0
            && bus_rdata_o[9:0] == 10'h0) else $error("bad control read");
    a_dout_idle:
        assert property (!link_sel_i [*6] |-> !link_dout_o) else $error("dout active outside frame");
    a_pop_step:
        assert property (rd_data && quiet_q > 4'h6 ##1 rd_data ##1 bus_rdata_o[15]
            |-> bus_rdata_o[31:16] == $past(bus_rdata_o[31:16]) - 16'h1) else $error("count step wrong");
    c_valid_read: cover property (rd_data ##1 bus_rdata_o[15]);
    c_tx_full: cover property (rd_ctrl ##1 bus_rdata_o[31:16] == 16'h0);
    c_frame: cover property ($rose(link_sel_i));
endmodule

bind jcu_top jcu_checker #(.DEPTH(DEPTH), .CNT_W(CNT_W)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .link_clk_i(link_clk_i), .link_sel_i(link_sel_i),
    .link_din_i(link_din_i), .link_dout_o(link_dout_o));

/* File: jcu_fifo.v */
/*
 * synchronous fifo with a registered head word and occupancy count.
 * assumes push and pop come from logic on the same clock.
 */
`include "jcu_map.vh"

module jcu_fifo #(
    parameter WIDTH = `JCU_CHAR_W,
    parameter DEPTH = `JCU_FIFO_DEPTH,
    parameter CNT_W = `JCU_FIFO_CNT_W,
    parameter PTR_W = 6
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    // occupancy
    output wire [CNT_W-1:0] count_o
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr_q;
    reg [PTR_W-1:0] rd_ptr_q;
    reg [CNT_W-1:0] count_q;
    reg [WIDTH-1:0] head_q;
    wire push;
    wire pop;
    wire empty_after_pop;
    wire [PTR_W-1:0] rd_next;

    assign in_ready_o = (count_q != DEPTH[CNT_W-1:0]);
    assign out_valid_o = (count_q != {CNT_W{1'b0}});
    assign out_data_o = head_q;
    assign count_o = count_q;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign rd_next = rd_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
    assign empty_after_pop = (count_q == {CNT_W{1'b0}}) ||
                             (pop && (count_q == {{(CNT_W-1){1'b0}}, 1'b1}));

    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= {PTR_W{1'b0}};
            rd_ptr_q <= {PTR_W{1'b0}};
            count_q <= {CNT_W{1'b0}};
            head_q <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_next;
            end
            if (push && !pop) begin
                count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
            if (push && empty_after_pop) begin
                head_q <= in_data_i;
            end else if (pop) begin
                head_q <= mem[rd_next];
            end
        end
    end

endmodule

/* File: jcu_host_model.sv */
/*
 * host end of the framed character link.
 * assumes the bench calls frame() one at a time, select idle low.
 */
module jcu_host_model (
    // link pins
    output logic link_clk_o,
    output logic link_sel_o,
    output logic link_din_o,
    input wire link_dout_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_clk_o = 1'b0;
        link_sel_o = 1'b0;
        link_din_o = 1'b1;
    end
    // valid bit then char, lsb first both ways; clock still between frames
    task frame(input logic [8:0] tx, output logic [8:0] rx);
        link_sel_o = 1'b1;
        #200;
        for (int i = 0; i < 9; i++) begin
            link_din_o = tx[i];
            #62.5 link_clk_o = 1'b1;
            rx[i] = link_dout_i;
            #62.5 link_clk_o = 1'b0;
        end
        #62.5 link_sel_o = 1'b0;
        link_din_o = ~link_din_o;
        #200;
    endtask
endmodule

/* File: jcu_map.vh */
/*
 * register map, field positions, reset values and link framing
 * constants for the character link block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef JCU_MAP_VH
`define JCU_MAP_VH

// register byte addresses
`define JCU_DATA_ADDR 32'hFF201000
`define JCU_CTRL_ADDR 32'hFF201004

// field positions
`define JCU_CNT_LSB 16
`define JCU_CNT_MSB 31
`define JCU_RVALID_BIT 15
`define JCU_AC_BIT 10
`define JCU_CHAR_MSB 7
`define JCU_CHAR_LSB 0

// fifo sizing
`define JCU_FIFO_DEPTH 64
`define JCU_FIFO_CNT_W 7
`define JCU_CHAR_W 8

// link framing: one valid bit then eight data bits, lsb first
`define JCU_FRAME_BITS 4'h9
`define JCU_FRAME_CNT_W 4

// reset values
`define JCU_AC_RST 1'b0
`define JCU_RDATA_RST 32'h00000000
`define JCU_TDO_RST 1'b0

`endif

/* File: jcu_top.v */
/*
 * character link block: memory-mapped data and control registers,
 * a receive fifo and a transmit fifo, and a framed serial link to the host.
 * assumes a single-cycle read and write strobe from the processor side and
 * a host link clock slower than a quarter of sys_clk_i.
 */
// Behaviour
// - data register decoded at its fixed address
// - control register decoded at its fixed address
// - host characters queue in 64-entry receive fifo
// - data bits 31-16 give receive count
// - host characters dropped when receive fifo full
// - bit 15 set whenever receive fifo nonempty
// - data read pops head, returns decremented count
// - empty receive fifo reads valid bit zero
// - outgoing characters queue in 64-entry transmit fifo
// - data write pushes low byte for transmit
// - data write leaves receive side untouched
// - control bits 31-16 give free transmit slots
// - data write dropped when transmit fifo full
// - bit 10 set once host used link
// - writing one clears accessed flag; zero keeps
`include "jcu_map.vh"

module jcu_top #(
    parameter DEPTH = `JCU_FIFO_DEPTH,
    parameter CNT_W = `JCU_FIFO_CNT_W
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // processor register port
    input wire [31:0] bus_addr_i,
    input wire bus_rd_i,
    input wire bus_wr_i,
    input wire [31:0] bus_wdata_i,
    output wire [31:0] bus_rdata_o,
    output wire bus_ack_o,
    // host link
    input wire link_clk_i,
    input wire link_sel_i,
    input wire link_din_i,
    output wire link_dout_o
);

    // register port state
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg ack_q;
    reg ack_d;
    reg host_accessed_flag_q;
    reg host_accessed_flag_d;

    // link synchronisers
    reg clk_meta_q;
    reg clk_sync_q;
    reg clk_prev_q;
    reg sel_meta_q;
    reg sel_sync_q;
    reg sel_prev_q;
    reg din_meta_q;
    reg din_sync_q;

    // link framing state
    reg [`JCU_FRAME_BITS-1:0] shift_in_q;
    reg [`JCU_FRAME_BITS-1:0] shift_in_d;
    reg [`JCU_FRAME_BITS-1:0] shift_out_q;
    reg [`JCU_FRAME_BITS-1:0] shift_out_d;
    reg [`JCU_FRAME_CNT_W-1:0] bit_cnt_q;
    reg [`JCU_FRAME_CNT_W-1:0] bit_cnt_d;
    reg dout_q;
    reg dout_d;

    // decode
    wire hit_data;
    wire hit_ctrl;
    wire rd_data;
    wire rd_ctrl;
    wire wr_data;
    wire wr_ctrl;

    // link events
    wire clk_rise;
    wire clk_fall;
    wire frame_start;
    wire frame_end;
    wire frame_ok;

    // fifo wiring
    wire rx_push_valid;
    wire rx_ready;
    wire rx_valid;
    wire rx_pop;
    wire [`JCU_CHAR_W-1:0] rx_head;
    wire [CNT_W-1:0] rx_count;
    wire tx_push_valid;
    wire tx_ready;
    wire tx_valid;
    wire tx_pop;
    wire [`JCU_CHAR_W-1:0] tx_head;
    wire [CNT_W-1:0] tx_count;

    // derived fields
    wire [15:0] rx_count_field;
    wire [15:0] tx_space_field;
    wire [CNT_W-1:0] rx_count_after;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign hit_data = (bus_addr_i == `JCU_DATA_ADDR);
    assign hit_ctrl = (bus_addr_i == `JCU_CTRL_ADDR);
    assign rd_data = bus_rd_i & hit_data;
    assign rd_ctrl = bus_rd_i & hit_ctrl;
    assign wr_data = bus_wr_i & hit_data;
    assign wr_ctrl = bus_wr_i & hit_ctrl;

    // ------------------------------------------------------------
    // receive fifo: host to processor
    // ------------------------------------------------------------
    assign rx_push_valid = frame_ok & shift_in_q[0];
    assign rx_pop = rd_data;

    jcu_fifo #(
        .WIDTH(`JCU_CHAR_W),
        .DEPTH(DEPTH),
        .CNT_W(CNT_W)
    ) u_rx_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(rx_push_valid),
        .in_ready_o(rx_ready),
        .in_data_i(shift_in_q[`JCU_FRAME_BITS-1:1]),
        .out_valid_o(rx_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rx_head),
        .count_o(rx_count)
    );

    // ------------------------------------------------------------
    // transmit fifo: processor to host
    // ------------------------------------------------------------
    assign tx_push_valid = wr_data;
    assign tx_pop = frame_start;

    jcu_fifo #(
        .WIDTH(`JCU_CHAR_W),
        .DEPTH(DEPTH),
        .CNT_W(CNT_W)
    ) u_tx_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(tx_push_valid),
        .in_ready_o(tx_ready),
        .in_data_i(bus_wdata_i[`JCU_CHAR_MSB:`JCU_CHAR_LSB]),
        .out_valid_o(tx_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_head),
        .count_o(tx_count)
    );

    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    assign rx_count_after = rx_valid ? (rx_count - {{(CNT_W-1){1'b0}}, 1'b1}) : rx_count;
    assign rx_count_field = {{(16-CNT_W){1'b0}}, rx_count_after};
    assign tx_space_field = {{(16-CNT_W){1'b0}}, DEPTH[CNT_W-1:0] - tx_count};

    // ------------------------------------------------------------
    // register read path and accessed flag
    // ------------------------------------------------------------
    always @* begin
        rdata_d = `JCU_RDATA_RST;
        ack_d = bus_rd_i | bus_wr_i;
        host_accessed_flag_d = host_accessed_flag_q;
        if (rd_data) begin
            rdata_d[`JCU_CNT_MSB:`JCU_CNT_LSB] = rx_count_field;
            rdata_d[`JCU_RVALID_BIT] = rx_valid;
            rdata_d[`JCU_CHAR_MSB:`JCU_CHAR_LSB] = rx_head;
        end else if (rd_ctrl) begin
            rdata_d[`JCU_CNT_MSB:`JCU_CNT_LSB] = tx_space_field;
            rdata_d[`JCU_AC_BIT] = host_accessed_flag_q;
        end
        if (wr_ctrl && bus_wdata_i[`JCU_AC_BIT]) begin
            host_accessed_flag_d = 1'b0;
        end
        if (frame_ok) begin
            host_accessed_flag_d = 1'b1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_q <= `JCU_RDATA_RST;
            ack_q <= 1'b0;
            host_accessed_flag_q <= `JCU_AC_RST;
        end else begin
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            host_accessed_flag_q <= host_accessed_flag_d;
        end
    end

    // ------------------------------------------------------------
    // link input synchronisers
    // ------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            clk_meta_q <= 1'b0;
            clk_sync_q <= 1'b0;
            clk_prev_q <= 1'b0;
            sel_meta_q <= 1'b0;
            sel_sync_q <= 1'b0;
            sel_prev_q <= 1'b0;
            din_meta_q <= 1'b0;
            din_sync_q <= 1'b0;
        end else begin
            clk_meta_q <= link_clk_i;
            clk_sync_q <= clk_meta_q;
            clk_prev_q <= clk_sync_q;
            sel_meta_q <= link_sel_i;
            sel_sync_q <= sel_meta_q;
            sel_prev_q <= sel_sync_q;
            din_meta_q <= link_din_i;
            din_sync_q <= din_meta_q;
        end
    end

    assign clk_rise = clk_sync_q & ~clk_prev_q;
    assign clk_fall = ~clk_sync_q & clk_prev_q;
    assign frame_start = sel_sync_q & ~sel_prev_q;
    assign frame_end = ~sel_sync_q & sel_prev_q;
    assign frame_ok = frame_end & (bit_cnt_q == `JCU_FRAME_BITS);

    // ------------------------------------------------------------
    // link framing
    // each frame carries one valid bit then one character, lsb first,
    // in both directions at once; short or long frames are not received, but each frame start still pops the transmit head
    // ------------------------------------------------------------
    always @* begin
        shift_in_d = shift_in_q;
        shift_out_d = shift_out_q;
        bit_cnt_d = bit_cnt_q;
        dout_d = dout_q;
        if (frame_start) begin
            shift_out_d = {tx_head, tx_valid};
            bit_cnt_d = {`JCU_FRAME_CNT_W{1'b0}};
            dout_d = tx_valid;
        end else if (sel_sync_q) begin
            if (clk_rise) begin
                shift_in_d = {din_sync_q, shift_in_q[`JCU_FRAME_BITS-1:1]};
                if (bit_cnt_q != {`JCU_FRAME_CNT_W{1'b1}}) begin
                    bit_cnt_d = bit_cnt_q + {{(`JCU_FRAME_CNT_W-1){1'b0}}, 1'b1};
                end
            end
            if (clk_fall) begin
                shift_out_d = {1'b0, shift_out_q[`JCU_FRAME_BITS-1:1]};
                dout_d = shift_out_q[1];
            end
        end else begin
            dout_d = `JCU_TDO_RST;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            shift_in_q <= {`JCU_FRAME_BITS{1'b0}};
            shift_out_q <= {`JCU_FRAME_BITS{1'b0}};
            bit_cnt_q <= {`JCU_FRAME_CNT_W{1'b0}};
            dout_q <= `JCU_TDO_RST;
        end else begin
            shift_in_q <= shift_in_d;
            shift_out_q <= shift_out_d;
            bit_cnt_q <= bit_cnt_d;
            dout_q <= dout_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_rdata_o = rdata_q;
    assign bus_ack_o = ack_q;
    assign link_dout_o = dout_q;

endmodule

/* File: jcu_top_tb_top.sv */
/*
 * self-checking bench for jcu_top with a host link model.
 * assumes jcu_checker is bound from its own file.
 */
`include "jcu_map.vh"
module jcu_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] bus_addr_i = 32'h0;
    logic bus_rd_i = 1'b0;
    logic bus_wr_i = 1'b0;
    logic [31:0] bus_wdata_i = 32'h0;
    wire [31:0] bus_rdata_o;
    wire bus_ack_o;
    wire link_clk_i, link_sel_i, link_din_i, link_dout_o;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    logic [31:0] rq[$];
    logic [31:0] t[8];
    logic [8:0] rx;
    logic [7:0] c;
    jcu_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i),
        .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o),
        .link_clk_i(link_clk_i), .link_sel_i(link_sel_i), .link_din_i(link_din_i), .link_dout_o(link_dout_o));
    jcu_host_model host (.link_clk_o(link_clk_i), .link_sel_o(link_sel_i), .link_din_o(link_din_i),
        .link_dout_i(link_dout_o));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end
    function automatic logic [31:0] dexp(input int cnt, input logic [7:0] ch);
        return {cnt[15:0], 1'b1, 7'h00, ch};
    endfunction
    function automatic logic [31:0] cexp(input int space, input logic ac);
        return {space[15:0], 5'h00, ac, 10'h000};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobe held n cycles: n accesses, each answer queued
    task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input int n);
        @(posedge sys_clk_i);
        bus_wr_i <= w;
        bus_rd_i <= !w;
        bus_addr_i <= a;
        bus_wdata_i <= d;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            if (i == n - 1) begin
                bus_wr_i <= 1'b0;
                bus_rd_i <= 1'b0;
            end
            #1;
            chk({31'h0, bus_ack_o}, 32'h1);
            rq.push_back(bus_rdata_o);
        end
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        acc(1'b0, a, 32'h0, 1);
        chk(rq.pop_back() & m, e);
    endtask
    task xfer(input logic [8:0] tx, input logic [8:0] ex);
        host.frame(tx, rx);
        chk({23'h0, rx & (ex[0] ? 9'h1FF : 9'h001)}, {23'h0, ex});
    endtask
    task complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(51452));
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(`JCU_CTRL_ADDR, cexp(64, 1'b0));
        rd(`JCU_DATA_ADDR, 32'h0, 32'hFFFFFF00);
        rd(32'hFF201008, 32'h0);
        // random burst to the host, then an empty frame
        n = 1 + $urandom_range(4);
        for (int i = 0; i < n; i++) begin
            t[i] = $urandom;
            acc(1'b1, `JCU_DATA_ADDR, t[i], 1);
        end
        rd(`JCU_CTRL_ADDR, cexp(64 - n, 1'b0));
        for (int i = 0; i <= n; i++) begin
            xfer(9'h000, i < n ? {t[i][7:0], 1'b1} : 9'h000);
        end
        rd(`JCU_CTRL_ADDR, cexp(64, 1'b1));
        acc(1'b1, `JCU_CTRL_ADDR, 32'hFFFFFBFF, 1);
        rd(`JCU_CTRL_ADDR, cexp(64, 1'b1));
        acc(1'b1, `JCU_CTRL_ADDR, 32'h00000400, 1);
        rd(`JCU_CTRL_ADDR, cexp(64, 1'b0));
        // receive three, write one between, read back to back
        for (int i = 0; i < 4; i++) begin
            t[i] = $urandom;
        end
        for (int i = 0; i < 3; i++) begin
            xfer({t[i][7:0], 1'b1}, 9'h000);
        end
        acc(1'b1, `JCU_DATA_ADDR, t[3], 1);
        rq.delete();
        acc(1'b0, `JCU_DATA_ADDR, 32'h0, 4);
        for (int i = 0; i < 3; i++) begin
            chk(rq[i], dexp(2 - i, t[i][7:0]));
        end
        chk(rq[3] & 32'hFFFFFF00, 32'h0);
        xfer(9'h000, {t[3][7:0], 1'b1});
        // overfill both queues
        c = $urandom;
        acc(1'b1, `JCU_DATA_ADDR, {24'h0, c}, 64);
        acc(1'b1, `JCU_DATA_ADDR, {24'h0, ~c}, 1);
        rd(`JCU_CTRL_ADDR, cexp(0, 1'b1));
        for (int i = 0; i < 65; i++) begin
            xfer({c + 8'(i), 1'b1}, i < 64 ? {c, 1'b1} : 9'h000);
        end
        rq.delete();
        acc(1'b0, `JCU_DATA_ADDR, 32'h0, 65);
        for (int i = 0; i < 64; i++) begin
            chk(rq[i], dexp(63 - i, c + 8'(i)));
        end
        chk(rq[64] & 32'hFFFFFF00, 32'h0);
        complete_run();
    end
endmodule
